//--- eplc_defines.svh
// eplc_defines.svh: preload word addresses, field positions, reset values
`ifndef EPLC_DEFINES_SVH
`define EPLC_DEFINES_SVH

// ----------------------------------------------------------------
// preload word addresses (port 0 base, next port two bytes on)
// ----------------------------------------------------------------
`define EPLC_ADDR_SLOT_BASE   8'h60
`define EPLC_ADDR_PWR_BASE    8'h70
`define EPLC_ADDR_PM_BASE     8'h80
`define EPLC_ADDR_STEP        8'h02

// ----------------------------------------------------------------
// slot word field positions
// ----------------------------------------------------------------
`define EPLC_SLOT_IMPL_BIT    0
`define EPLC_SLOT_CLK_BIT     1
`define EPLC_SLOT_DSI_BIT     2
`define EPLC_SLOT_LOW_PRIORITY_VC_COUNT_BIT    3
`define EPLC_SLOT_PNUM_LSB    4
`define EPLC_SLOT_PNUM_MSB    6
`define EPLC_SLOT_TCMAP_LSB   9
`define EPLC_SLOT_TCMAP_MSB   15

// ----------------------------------------------------------------
// power budget word field positions
// ----------------------------------------------------------------
`define EPLC_PWR_BASE_LSB     0
`define EPLC_PWR_BASE_MSB     7
`define EPLC_PWR_SCALE_LSB    8
`define EPLC_PWR_SCALE_MSB    9
`define EPLC_PWR_PMST_LSB     10
`define EPLC_PWR_PMST_MSB     11
`define EPLC_PWR_SYSALLOC_BIT 15

// ----------------------------------------------------------------
// power-management control word field positions
// ----------------------------------------------------------------
`define EPLC_PM_CTRL_LSB      0
`define EPLC_PM_CTRL_MSB      5
`define EPLC_PM_RXPOL_BIT     6
`define EPLC_PM_VGA_BIT       7
`define EPLC_PM_PHY_LSB       8
`define EPLC_PM_PHY_MSB       15

// ----------------------------------------------------------------
// reset values of the loaded fields
// ----------------------------------------------------------------
`define EPLC_RST_FLAG         1'h0
`define EPLC_RST_TCMAP        7'h00
`define EPLC_RST_BYTE         8'h00
`define EPLC_RST_PAIR         2'h0
`define EPLC_RST_PMCTRL       6'h00

`endif

//--- eplc_eeprom_model.sv
// eplc_eeprom_model.sv: behavioural serial memory reader that streams preload words
`timescale 1ns/100ps

module eplc_eeprom_model (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_start,
	input  wire logic [7:0]   i_gap,
	input  wire logic [143:0] i_image,
	output logic              o_busy,
	output logic              o_word_valid,
	output logic [7:0]        o_word_addr,
	output logic [15:0]       o_word_data
);

	logic [3:0] idx;
	logic [7:0] wait_cnt;

	// ----------------------------------------------------------------
	// word placement
	// ----------------------------------------------------------------
	// slot, power and pm words
	function automatic logic [7:0] word_addr(input logic [3:0] i);
		if (i < 4'h3) begin
			word_addr = 8'h60 + 8'(2 * i);
		end else if (i < 4'h6) begin
			word_addr = 8'h70 + 8'(2 * (i - 4'h3));
		end else if (i < 4'h9) begin
			word_addr = 8'h80 + 8'(2 * (i - 4'h6));
		end else begin
			// unmapped slot address, must be ignored by the loader
			word_addr = 8'h66;
		end
	endfunction

	// ----------------------------------------------------------------
	// streaming
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_busy       <= 1'h0;
			o_word_valid <= 1'h0;
			o_word_addr  <= 8'h00;
			o_word_data  <= 16'h0000;
			idx          <= 4'h0;
			wait_cnt     <= 8'h00;
		end else begin
			o_word_valid <= 1'h0;
			// between words the lines wander so a stale value is never mistaken for data
			o_word_addr  <= ~o_word_addr;
			o_word_data  <= o_word_data ^ 16'h5a5a;
			if (!o_busy && i_start) begin
				o_busy   <= 1'h1;
				idx      <= 4'h0;
				wait_cnt <= 8'h00;
			end else if (o_busy) begin
				if (wait_cnt != 8'h00) begin
					wait_cnt <= wait_cnt - 8'h01;
				end else begin
					o_word_valid <= 1'h1;
					o_word_addr  <= word_addr(idx);
					o_word_data  <= (idx < 4'h9) ? i_image[idx*16 +: 16] : 16'hffff;
					wait_cnt     <= i_gap;
					idx          <= idx + 4'h1;
					if (idx == 4'h9) begin
						o_busy <= 1'h0;
					end
				end
			end
		end
	end

endmodule // eplc_eeprom_model

//--- eplc_loader.sv
// eplc_loader.sv: preload word decoder and per-port configuration field store
//
// What this block does
// - slot word bit 0 sets the slot-implemented bit of ports 1 and 2.
// - slot word bit 1 sets the connector reference clock flag.
// - slot word bit 2 sets the device-specific initialization flag.
// - slot word bit 3 counts VC1 as a low-priority VC.
// - slot word bits 6:4 give the reported logical port number.
// - slot word bits 15:9 map traffic classes onto VC0.
// - words 70h, 72h, 74h give base power of ports 0, 1, 2.
// - power word bits 9:8 load the data scale field.
// - power word bits 11:10 load the power-management state field.
// - power word bit 15 loads the system-allocated flag.
// - word 80h bits 5:0 load port 0 link power-management controls.
// - pm word bit 6 disables receiver polarity inversion.
// - pm word bit 7 enables legacy VGA decoding.
// - pm word bits 15:8 load the vendor PHY control byte.
// - word 60h carries the slot layout for port 0.
// - words 82h and 84h carry the pm layout for ports 1, 2.
`timescale 1ns/100ps
`include "eplc_defines.svh"

module eplc_loader
	import eplc_pkg::*;
#(
	parameter int NUM_PORTS = 3
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_word_valid,
	input  wire logic [7:0]             i_word_addr,
	input  wire logic [15:0]            i_word_data,
	input  wire logic                   i_load_done,
	output logic                        o_cfg_ready,
	output logic [NUM_PORTS-1:0]        o_slot_impl,
	output logic [NUM_PORTS-1:0]        o_slot_clk,
	output logic [NUM_PORTS-1:0]        o_dsi,
	output logic [NUM_PORTS-1:0]        o_low_priority_vc_count,
	output logic [3*NUM_PORTS-1:0]      o_port_num,
	output logic [7*NUM_PORTS-1:0]      o_tc_map,
	output logic [8*NUM_PORTS-1:0]      o_base_power,
	output logic [2*NUM_PORTS-1:0]      o_data_scale,
	output logic [2*NUM_PORTS-1:0]      o_pm_state,
	output logic [NUM_PORTS-1:0]        o_sys_alloc,
	output logic [6*NUM_PORTS-1:0]      o_pm_ctrl,
	output logic [NUM_PORTS-1:0]        o_rx_pol_dis,
	output logic [NUM_PORTS-1:0]        o_vga_en,
	output logic [8*NUM_PORTS-1:0]      o_phy_ctrl
);

	// ----------------------------------------------------------------
	// load sequencing
	// ----------------------------------------------------------------
	eplc_ctl_type ctl;
	eplc_ctl_type next_ctl;
	logic         accept;

	// first address past the last slot word; the memory may send it and it must land nowhere
	localparam logic [7:0] ADDR_PAST_SLOTS = 8'(`EPLC_ADDR_SLOT_BASE + `EPLC_ADDR_STEP * NUM_PORTS);

	// words are taken only while loading; once the port answers the host,
	// a late word would change fields under a running driver, so it is dropped
	assign accept = (ctl.state == EPLC_LOAD) && i_word_valid;

	always_comb begin
		next_ctl = ctl;
		case (ctl.state)
			EPLC_LOAD: begin
				if (i_load_done) begin
					next_ctl.state = EPLC_SETTLE;
				end
			end
			EPLC_SETTLE: begin
				next_ctl.state = EPLC_READY;
				next_ctl.ready = 1'b1;
			end
			EPLC_READY: begin
				next_ctl.ready = 1'b1;
			end
			default: begin
				next_ctl.state = EPLC_LOAD;
				next_ctl.ready = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctl <= '{state: EPLC_LOAD, ready: 1'b0};
		end else begin
			ctl <= next_ctl;
		end
	end

	assign o_cfg_ready = ctl.ready;

	// ----------------------------------------------------------------
	// per-port word decode and field store
	// ----------------------------------------------------------------
	logic [NUM_PORTS-1:0] slot_we;
	logic [NUM_PORTS-1:0] pwr_we;
	logic [NUM_PORTS-1:0] pm_we;

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			localparam logic [7:0] OFS = 8'(`EPLC_ADDR_STEP * p);

			assign slot_we[p] = accept && (i_word_addr == 8'(`EPLC_ADDR_SLOT_BASE + OFS));
			assign pwr_we[p]  = accept && (i_word_addr == 8'(`EPLC_ADDR_PWR_BASE + OFS));
			assign pm_we[p]   = accept && (i_word_addr == 8'(`EPLC_ADDR_PM_BASE + OFS));

			eplc_port_fields #(
				.PORT_ID (3'(p))
			) u_fields (
				.i_clk        (i_clk),
				.i_rst        (i_rst),
				.i_slot_we    (slot_we[p]),
				.i_pwr_we     (pwr_we[p]),
				.i_pm_we      (pm_we[p]),
				.i_data       (i_word_data),
				.o_slot_impl  (o_slot_impl[p]),
				.o_slot_clk   (o_slot_clk[p]),
				.o_dsi        (o_dsi[p]),
				.o_low_priority_vc_count       (o_low_priority_vc_count[p]),
				.o_port_num   (o_port_num[3*p +: 3]),
				.o_tc_map     (o_tc_map[7*p +: 7]),
				.o_base_power (o_base_power[8*p +: 8]),
				.o_data_scale (o_data_scale[2*p +: 2]),
				.o_pm_state   (o_pm_state[2*p +: 2]),
				.o_sys_alloc  (o_sys_alloc[p]),
				.o_pm_ctrl    (o_pm_ctrl[6*p +: 6]),
				.o_rx_pol_dis (o_rx_pol_dis[p]),
				.o_vga_en     (o_vga_en[p]),
				.o_phy_ctrl   (o_phy_ctrl[8*p +: 8])
			);

			// ----------------------------------------------------------------
			// checks per port
			// ----------------------------------------------------------------
			a_slot_impl_load: assert property (@(posedge i_clk) disable iff (i_rst)
				slot_we[p] |=> o_slot_impl[p] == ((p == 0) ? 1'b0 : $past(i_word_data[`EPLC_SLOT_IMPL_BIT])))
				else $error("slot implemented bit not loaded");
			a_slot_clk_load: assert property (@(posedge i_clk) disable iff (i_rst)
				slot_we[p] |=> o_slot_clk[p] == $past(i_word_data[`EPLC_SLOT_CLK_BIT]))
				else $error("slot clock bit not loaded");
			a_dsi_load: assert property (@(posedge i_clk) disable iff (i_rst)
				slot_we[p] |=> o_dsi[p] == $past(i_word_data[`EPLC_SLOT_DSI_BIT]))
				else $error("init required bit not loaded");
			a_low_priority_vc_count_load: assert property (@(posedge i_clk) disable iff (i_rst)
				slot_we[p] |=> o_low_priority_vc_count[p] == $past(i_word_data[`EPLC_SLOT_LOW_PRIORITY_VC_COUNT_BIT]))
				else $error("low priority vc bit not loaded");
			a_port_num_load: assert property (@(posedge i_clk) disable iff (i_rst)
				slot_we[p] |=> o_port_num[3*p +: 3] ==
					$past(i_word_data[`EPLC_SLOT_PNUM_MSB:`EPLC_SLOT_PNUM_LSB]))
				else $error("port number not loaded");
			a_tc_map_load: assert property (@(posedge i_clk) disable iff (i_rst)
				slot_we[p] |=> o_tc_map[7*p +: 7] ==
					$past(i_word_data[`EPLC_SLOT_TCMAP_MSB:`EPLC_SLOT_TCMAP_LSB]))
				else $error("tc map not loaded");
			a_base_power_load: assert property (@(posedge i_clk) disable iff (i_rst)
				pwr_we[p] |=> o_base_power[8*p +: 8] ==
					$past(i_word_data[`EPLC_PWR_BASE_MSB:`EPLC_PWR_BASE_LSB]))
				else $error("base power not loaded");
			a_data_scale_load: assert property (@(posedge i_clk) disable iff (i_rst)
				pwr_we[p] |=> o_data_scale[2*p +: 2] ==
					$past(i_word_data[`EPLC_PWR_SCALE_MSB:`EPLC_PWR_SCALE_LSB]))
				else $error("data scale not loaded");
			a_pm_state_load: assert property (@(posedge i_clk) disable iff (i_rst)
				pwr_we[p] |=> o_pm_state[2*p +: 2] ==
					$past(i_word_data[`EPLC_PWR_PMST_MSB:`EPLC_PWR_PMST_LSB]))
				else $error("pm state not loaded");
			a_sys_alloc_load: assert property (@(posedge i_clk) disable iff (i_rst)
				pwr_we[p] |=> o_sys_alloc[p] == $past(i_word_data[`EPLC_PWR_SYSALLOC_BIT]))
				else $error("system allocated bit not loaded");
			a_pm_ctrl_load: assert property (@(posedge i_clk) disable iff (i_rst)
				pm_we[p] |=> o_pm_ctrl[6*p +: 6] ==
					$past(i_word_data[`EPLC_PM_CTRL_MSB:`EPLC_PM_CTRL_LSB]))
				else $error("pm control not loaded");
			a_rx_pol_load: assert property (@(posedge i_clk) disable iff (i_rst)
				pm_we[p] |=> o_rx_pol_dis[p] == $past(i_word_data[`EPLC_PM_RXPOL_BIT]))
				else $error("rx polarity disable not loaded");
			a_vga_load: assert property (@(posedge i_clk) disable iff (i_rst)
				pm_we[p] |=> o_vga_en[p] == $past(i_word_data[`EPLC_PM_VGA_BIT]))
				else $error("vga decode bit not loaded");
			a_phy_ctrl_load: assert property (@(posedge i_clk) disable iff (i_rst)
				pm_we[p] |=> o_phy_ctrl[8*p +: 8] ==
					$past(i_word_data[`EPLC_PM_PHY_MSB:`EPLC_PM_PHY_LSB]))
				else $error("vendor phy byte not loaded");
			a_slot_addr_decode: assert property (@(posedge i_clk) disable iff (i_rst)
				slot_we[p] |-> i_word_addr == 8'(`EPLC_ADDR_SLOT_BASE + OFS))
				else $error("slot word taken at wrong address");
			a_pm_addr_decode: assert property (@(posedge i_clk) disable iff (i_rst)
				pm_we[p] |-> i_word_addr == 8'(`EPLC_ADDR_PM_BASE + OFS))
				else $error("pm word taken at wrong address");
			a_fields_hold: assert property (@(posedge i_clk) disable iff (i_rst)
				!slot_we[p] && !pwr_we[p] && !pm_we[p] |=>
					$stable(o_port_num[3*p +: 3]) && $stable(o_base_power[8*p +: 8])
					&& $stable(o_phy_ctrl[8*p +: 8]) && $stable(o_tc_map[7*p +: 7]))
				else $error("field changed without its word");

			// one check per word kind: a field may move only at the edge after its own word
			a_pwr_addr_decode: assert property (@(posedge i_clk) disable iff (i_rst)
				pwr_we[p] |-> i_word_addr == 8'(`EPLC_ADDR_PWR_BASE + OFS))
				else $error("power word taken at wrong address");
			a_slot_hold: assert property (@(posedge i_clk) disable iff (i_rst)
				!slot_we[p] |=>
					$stable(o_slot_impl[p]) && $stable(o_slot_clk[p])
					&& $stable(o_dsi[p]) && $stable(o_low_priority_vc_count[p])
					&& $stable(o_port_num[3*p +: 3]) && $stable(o_tc_map[7*p +: 7]))
				else $error("slot field changed without slot word");
			a_pwr_hold: assert property (@(posedge i_clk) disable iff (i_rst)
				!pwr_we[p] |=>
					$stable(o_base_power[8*p +: 8]) && $stable(o_data_scale[2*p +: 2])
					&& $stable(o_pm_state[2*p +: 2]) && $stable(o_sys_alloc[p]))
				else $error("power field changed without power word");
			a_pm_hold: assert property (@(posedge i_clk) disable iff (i_rst)
				!pm_we[p] |=>
					$stable(o_pm_ctrl[6*p +: 6]) && $stable(o_rx_pol_dis[p])
					&& $stable(o_vga_en[p]) && $stable(o_phy_ctrl[8*p +: 8]))
				else $error("pm field changed without pm word");
			// a late word must not reach a port that already answers the host
			a_late_word_dropped: assert property (@(posedge i_clk) disable iff (i_rst)
				o_cfg_ready |=> $stable(o_base_power[8*p +: 8]) && $stable(o_phy_ctrl[8*p +: 8])
					&& $stable(o_tc_map[7*p +: 7]) && $stable(o_slot_clk[p]))
				else $error("field changed after config ready");
			a_reset_fields: assert property (@(posedge i_clk) disable iff (i_rst)
				$fell(i_rst) |-> o_port_num[3*p +: 3] == 3'(p) && o_tc_map[7*p +: 7] == `EPLC_RST_TCMAP
					&& o_phy_ctrl[8*p +: 8] == `EPLC_RST_BYTE && o_base_power[8*p +: 8] == `EPLC_RST_BYTE)
				else $error("field not at reset value after reset");
			// the upstream port has no slot, so its bit never loads
			if (p == 0) begin : g_upstream
				a_upstream_no_slot: assert property (@(posedge i_clk) disable iff (i_rst)
					o_slot_impl[p] == 1'b0)
					else $error("slot implemented set on upstream port");
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// sequencing checks and covers
	// ----------------------------------------------------------------
	a_ready_after_done: assert property (@(posedge i_clk) disable iff (i_rst)
		(ctl.state == EPLC_LOAD) && i_load_done |-> !o_cfg_ready ##1 !o_cfg_ready ##1 o_cfg_ready)
		else $error("config ready not two cycles after load done");
	a_no_write_ready: assert property (@(posedge i_clk) disable iff (i_rst)
		o_cfg_ready |-> !(|slot_we) && !(|pwr_we) && !(|pm_we))
		else $error("word taken after config ready");
	a_ready_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
		o_cfg_ready |=> o_cfg_ready)
		else $error("config ready dropped without reset");
	a_state_onehot: assert property (@(posedge i_clk) disable iff (i_rst)
		$onehot(ctl.state))
		else $error("load state not one-hot");
	a_ready_state: assert property (@(posedge i_clk) disable iff (i_rst)
		o_cfg_ready == (ctl.state == EPLC_READY))
		else $error("config ready disagrees with state");
	a_load_waits: assert property (@(posedge i_clk) disable iff (i_rst)
		(ctl.state == EPLC_LOAD) && !i_load_done |=> ctl.state == EPLC_LOAD)
		else $error("load ended without load done");
	a_settle_once: assert property (@(posedge i_clk) disable iff (i_rst)
		(ctl.state == EPLC_SETTLE) |=> ctl.state == EPLC_READY)
		else $error("settle lasted more than one cycle");
	// a repeated load done must not restart loading
	a_done_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
		(ctl.state != EPLC_LOAD) |=> ctl.state != EPLC_LOAD)
		else $error("loading restarted without reset");
	a_reset_state: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(i_rst) |-> ctl.state == EPLC_LOAD && !o_cfg_ready)
		else $error("load state not cleared by reset");
	a_settle_no_word: assert property (@(posedge i_clk) disable iff (i_rst)
		(ctl.state == EPLC_SETTLE) && i_word_valid |-> !(|slot_we) && !(|pwr_we) && !(|pm_we))
		else $error("word taken while settling");
	// a word in the cycle of load done still counts
	a_word_at_done: assert property (@(posedge i_clk) disable iff (i_rst)
		(ctl.state == EPLC_LOAD) && i_load_done && i_word_valid && i_word_addr == `EPLC_ADDR_PM_BASE |-> pm_we[0])
		else $error("word beside load done dropped");
	// odd addresses and the word past the last slot word map to no field
	a_refused_addr: assert property (@(posedge i_clk) disable iff (i_rst)
		i_word_valid && (i_word_addr[0] || i_word_addr == ADDR_PAST_SLOTS)
			|-> !(|slot_we) && !(|pwr_we) && !(|pm_we))
		else $error("word taken at unmapped address");

	c_slot_port2: cover property (@(posedge i_clk) disable iff (i_rst)
		slot_we[NUM_PORTS-1] ##[1:20] o_cfg_ready);
	c_all_kinds: cover property (@(posedge i_clk) disable iff (i_rst)
		(|slot_we) ##[1:10] (|pwr_we) ##[1:10] (|pm_we));
	c_late_word: cover property (@(posedge i_clk) disable iff (i_rst)
		o_cfg_ready && i_word_valid);
	c_no_words: cover property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_cfg_ready) && o_port_num[2:0] == 3'h0);
	c_word_at_done: cover property (@(posedge i_clk) disable iff (i_rst)
		accept && i_load_done);

endmodule // eplc_loader

//--- eplc_loader_bench.sv
// eplc_loader_bench.sv: self-checking testbench of the preload configuration loader
`timescale 1ns/100ps

module eplc_loader_bench
	import eplc_pkg::*;
;
	logic         i_clk;
	logic         i_rst;
	logic         load_done;
	logic         start;
	logic [7:0]   gap;
	logic [143:0] image;
	logic         busy;
	logic         word_valid;
	logic [7:0]   word_addr;
	logic [15:0]  word_data;
	logic         cfg_ready;
	logic [2:0]   slot_impl, slot_clk, dsi, low_priority_vc_count, sys_alloc, rx_pol_dis, vga_en;
	logic [8:0]   port_num;
	logic [20:0]  tc_map;
	logic [23:0]  base_power, phy_ctrl;
	logic [5:0]   data_scale, pm_state;
	logic [17:0]  pm_ctrl;
	logic [143:0] img_a, img_b, img_c;
	int           failures, n_tests, cycles;
	logic [31:0]  seed;

	eplc_loader #(.NUM_PORTS(3)) u_eplc_loader (.i_clk(i_clk), .i_rst(i_rst), .i_word_valid(word_valid),
		.i_word_addr(word_addr), .i_word_data(word_data), .i_load_done(load_done), .o_cfg_ready(cfg_ready),
		.o_slot_impl(slot_impl), .o_slot_clk(slot_clk), .o_dsi(dsi), .o_low_priority_vc_count(low_priority_vc_count), .o_port_num(port_num),
		.o_tc_map(tc_map), .o_base_power(base_power), .o_data_scale(data_scale), .o_pm_state(pm_state),
		.o_sys_alloc(sys_alloc), .o_pm_ctrl(pm_ctrl), .o_rx_pol_dis(rx_pol_dis), .o_vga_en(vga_en),
		.o_phy_ctrl(phy_ctrl));

	eplc_eeprom_model u_eplc_eeprom_model (.i_clk(i_clk), .i_rst(i_rst), .i_start(start), .i_gap(gap),
		.i_image(image), .o_busy(busy), .o_word_valid(word_valid), .o_word_addr(word_addr),
		.o_word_data(word_data));

	// ----------------------------------------------------------------
	// clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		i_clk = 1'h0;
		forever #50 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [143:0] rand_img();
		for (int i = 0; i < 9; i++) begin
			rand_img[i*16 +: 16] = 16'($random(seed));
		end
	endfunction

	// streams one image; the memory may be slow, so wait on its busy flag
	task automatic load(input logic [143:0] img, input logic [7:0] g);
		@(posedge i_clk);
		image <= img;
		gap   <= g;
		start <= 1'h1;
		@(posedge i_clk);
		start <= 1'h0;
		for (int k = 0; k < 300; k++) begin
			@(posedge i_clk);
			#1;
			if (!busy) break;
		end
		if (busy) begin
			failures++;
			end_of_test();
		end
	endtask

	task automatic finish_load();
		@(posedge i_clk);
		load_done <= 1'h1;
		@(posedge i_clk);
		load_done <= 1'h0;
		#1;
		check(32'(cfg_ready), 32'h0);
		@(posedge i_clk);
		#1;
		check(32'(cfg_ready), 32'h1);
	endtask

	task automatic check_reset();
		check(32'(cfg_ready), 32'h0);
		check(32'(slot_impl | slot_clk | dsi | low_priority_vc_count | sys_alloc | rx_pol_dis | vga_en), 32'h0);
		check(32'(tc_map), 32'h0);
		check(32'(base_power), 32'h0);
		check(32'({data_scale, pm_state}), 32'h0);
		check(32'(pm_ctrl), 32'h0);
		check(32'(phy_ctrl), 32'h0);
		check(32'(port_num), 32'({3'h2, 3'h1, 3'h0}));
	endtask

	task automatic check_fields(input logic [143:0] img);
		logic [15:0] s, w, m;
		for (int p = 0; p < 3; p++) begin
			s = img[p*16 +: 16];
			w = img[(3+p)*16 +: 16];
			m = img[(6+p)*16 +: 16];
			check(32'(slot_impl[p]), (p == 0) ? 32'h0 : 32'(s[0]));
			check(32'(slot_clk[p]), 32'(s[1]));
			check(32'(dsi[p]), 32'(s[2]));
			check(32'(low_priority_vc_count[p]), 32'(s[3]));
			check(32'(port_num[3*p +: 3]), 32'(s[6:4]));
			check(32'(tc_map[7*p +: 7]), 32'(s[15:9]));
			check(32'(base_power[8*p +: 8]), 32'(w[7:0]));
			check(32'(data_scale[2*p +: 2]), 32'(w[9:8]));
			check(32'(pm_state[2*p +: 2]), 32'(w[11:10]));
			check(32'(sys_alloc[p]), 32'(w[15]));
			check(32'(pm_ctrl[6*p +: 6]), 32'(m[5:0]));
			check(32'(rx_pol_dis[p]), 32'(m[6]));
			check(32'(vga_en[p]), 32'(m[7]));
			check(32'(phy_ctrl[8*p +: 8]), 32'(m[15:8]));
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed      = 32'hbdd8c2be;
		failures  = 0;
		n_tests   = 0;
		cycles    = 0;
		i_rst     = 1'h1;
		load_done = 1'h0;
		start     = 1'h0;
		gap       = 8'h00;
		image     = 144'h0;
		repeat (12) @(posedge i_clk);
		for (int r = 0; r < 5; r++) begin
			if (r > 0) begin
				// reset from a loaded state must bring everything back
				@(posedge i_clk);
				i_rst <= 1'h1;
				repeat (2) @(posedge i_clk);
			end
			i_rst <= 1'h0;
			@(posedge i_clk);
			#1;
			check_reset();
			img_a = rand_img();
			img_b = rand_img();
			if (r == 0) begin
				img_b = {144{1'h1}};
			end
			if (r == 1) begin
				img_a = {144{1'h1}};
				img_b = 144'h0;
			end
			// second image rewrites the first; last word wins
			load(img_a, 8'(r));
			load(img_b, 8'h00);
			finish_load();
			check_fields(img_b);
			// words after completion must be dropped
			img_c = rand_img();
			load(img_c, 8'h01);
			@(posedge i_clk);
			#1;
			check_fields(img_b);
		end
		end_of_test();
	end

endmodule // eplc_loader_bench

//--- eplc_pkg.sv
// eplc_pkg.sv: types of the preload configuration loader
package eplc_pkg;

	typedef enum logic [2:0] {
		EPLC_LOAD   = 3'h1,
		EPLC_SETTLE = 3'h2,
		EPLC_READY  = 3'h4
	} eplc_state_type;

	typedef struct packed {
		eplc_state_type state;
		logic           ready;
	} eplc_ctl_type;

	typedef struct packed {
		logic       slot_impl;
		logic       slot_clk;
		logic       dsi;
		logic       low_priority_vc_count;
		logic [2:0] port_num;
		logic [6:0] tc_map;
		logic [7:0] base_power;
		logic [1:0] data_scale;
		logic [1:0] pm_state;
		logic       sys_alloc;
		logic [5:0] pm_ctrl;
		logic       rx_pol_dis;
		logic       vga_en;
		logic [7:0] phy_ctrl;
	} eplc_fields_type;

endpackage

//--- eplc_port_fields.sv
// eplc_port_fields.sv: loaded configuration fields of one port
`timescale 1ns/100ps
`include "eplc_defines.svh"

module eplc_port_fields
	import eplc_pkg::*;
#(
	parameter logic [2:0] PORT_ID = 3'h0
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_slot_we,
	input  wire logic        i_pwr_we,
	input  wire logic        i_pm_we,
	input  wire logic [15:0] i_data,
	output logic             o_slot_impl,
	output logic             o_slot_clk,
	output logic             o_dsi,
	output logic             o_low_priority_vc_count,
	output logic [2:0]       o_port_num,
	output logic [6:0]       o_tc_map,
	output logic [7:0]       o_base_power,
	output logic [1:0]       o_data_scale,
	output logic [1:0]       o_pm_state,
	output logic             o_sys_alloc,
	output logic [5:0]       o_pm_ctrl,
	output logic             o_rx_pol_dis,
	output logic             o_vga_en,
	output logic [7:0]       o_phy_ctrl
);

	// port number resets to the physical index until a slot word renames it
	localparam eplc_fields_type RST_FIELDS = '{
		slot_impl:  `EPLC_RST_FLAG,
		slot_clk:   `EPLC_RST_FLAG,
		dsi:        `EPLC_RST_FLAG,
		low_priority_vc_count:       `EPLC_RST_FLAG,
		port_num:   PORT_ID,
		tc_map:     `EPLC_RST_TCMAP,
		base_power: `EPLC_RST_BYTE,
		data_scale: `EPLC_RST_PAIR,
		pm_state:   `EPLC_RST_PAIR,
		sys_alloc:  `EPLC_RST_FLAG,
		pm_ctrl:    `EPLC_RST_PMCTRL,
		rx_pol_dis: `EPLC_RST_FLAG,
		vga_en:     `EPLC_RST_FLAG,
		phy_ctrl:   `EPLC_RST_BYTE
	};

	eplc_fields_type f;
	eplc_fields_type next_f;

	always_comb begin
		next_f = f;
		if (i_slot_we) begin
			// downstream slots only
			// the upstream port has no slot, so bit 0 of its slot word is ignored
			if (PORT_ID != 3'h0) begin
				next_f.slot_impl = i_data[`EPLC_SLOT_IMPL_BIT];
			end
			next_f.slot_clk  = i_data[`EPLC_SLOT_CLK_BIT];
			next_f.dsi       = i_data[`EPLC_SLOT_DSI_BIT];
			next_f.low_priority_vc_count      = i_data[`EPLC_SLOT_LOW_PRIORITY_VC_COUNT_BIT];
			next_f.port_num  = i_data[`EPLC_SLOT_PNUM_MSB:`EPLC_SLOT_PNUM_LSB];
			next_f.tc_map    = i_data[`EPLC_SLOT_TCMAP_MSB:`EPLC_SLOT_TCMAP_LSB];
		end
		if (i_pwr_we) begin
			next_f.base_power = i_data[`EPLC_PWR_BASE_MSB:`EPLC_PWR_BASE_LSB];
			next_f.data_scale = i_data[`EPLC_PWR_SCALE_MSB:`EPLC_PWR_SCALE_LSB];
			next_f.pm_state   = i_data[`EPLC_PWR_PMST_MSB:`EPLC_PWR_PMST_LSB];
			next_f.sys_alloc  = i_data[`EPLC_PWR_SYSALLOC_BIT];
		end
		if (i_pm_we) begin
			next_f.pm_ctrl    = i_data[`EPLC_PM_CTRL_MSB:`EPLC_PM_CTRL_LSB];
			next_f.rx_pol_dis = i_data[`EPLC_PM_RXPOL_BIT];
			next_f.vga_en     = i_data[`EPLC_PM_VGA_BIT];
			next_f.phy_ctrl   = i_data[`EPLC_PM_PHY_MSB:`EPLC_PM_PHY_LSB];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			f <= RST_FIELDS;
		end else begin
			f <= next_f;
		end
	end

	assign o_slot_impl  = f.slot_impl;
	assign o_slot_clk   = f.slot_clk;
	assign o_dsi        = f.dsi;
	assign o_low_priority_vc_count       = f.low_priority_vc_count;
	assign o_port_num   = f.port_num;
	assign o_tc_map     = f.tc_map;
	assign o_base_power = f.base_power;
	assign o_data_scale = f.data_scale;
	assign o_pm_state   = f.pm_state;
	assign o_sys_alloc  = f.sys_alloc;
	assign o_pm_ctrl    = f.pm_ctrl;
	assign o_rx_pol_dis = f.rx_pol_dis;
	assign o_vga_en     = f.vga_en;
	assign o_phy_ctrl   = f.phy_ctrl;

endmodule // eplc_port_fields
